// ===== hw/irq_consts.svh
// Offsets, field positions, reset values and counts of the interrupt controller
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

`define OFS_FAULT_NEST     16'h0080
`define OFS_EDGE_VECTOR    16'h0082
`define OFS_FLAGS_0        16'h0084
`define OFS_FLAGS_1        16'h0086
`define OFS_FLAGS_2        16'h0088
`define OFS_ENABLES_0      16'h008C
`define OFS_ENABLES_1      16'h008E
`define OFS_ENABLES_2      16'h0600
`define OFS_PRIO_0         16'h0094
`define OFS_PRIO_1         16'h9600
`define OFS_PRIO_2         16'h0098
`define OFS_PRIO_3         16'h009A
`define OFS_PRIO_4         16'h009C
`define OFS_PRIO_5         16'h3600
`define OFS_PRIO_6         16'h00A0
`define OFS_PRIO_7         16'h00A2
`define OFS_PRIO_8         16'h00A4
`define OFS_PRIO_9         16'h00A6
`define OFS_PRIO_10        16'h00A8
`define OFS_ACTIVE_STATUS  16'h00B0
`define OFS_EVENT_STATUS   16'h00B2
`define OFS_EVENT_ENABLE   16'h00B4
`define OFS_EVENT_CLEAR    16'h00B6

`define FAULT_NEST_MASK    16'h871E
`define EDGE_VECTOR_MASK   16'h801F
`define ALT_VECTOR_BIT     15
`define FLAGS_2_MASK       16'h067F
`define PRIO_RESET         16'h4444
`define PRIO_RESET_9       16'h0444
`define PRIO_RESET_10      16'h0440
`define PRIO_MASK          16'h7777
`define PRIO_MASK_9        16'h0777
`define PRIO_MASK_10       16'h0770

`define SOURCE_COUNT       44
`define PRIO_REG_COUNT     11
`define FLAG_REG_COUNT     3
`define VECTOR_BASE        8
`define EVENT_COUNT        6
`define EVENT_WAKE_BIT     5

`define EXT0_FLAG_BIT      0
`define EXT1_FLAG_BIT      16
`define EXT2_FLAG_BIT      23
`define EXT3_FLAG_BIT      36
`define EXT4_FLAG_BIT      37

`endif

// ===== hw/irq_pkg.sv
// Types shared by the interrupt controller and its surroundings
package irq_pkg;

  typedef struct packed {
    logic [4:0]       status_flags;
    logic [3:0][15:0] work_regs;
  } context_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] level;
    logic [5:0] vector;
    logic       alt_table;
  } irq_req_t;

endpackage : irq_pkg

// ===== hw/vectored_irq_controller.sv
// Vectored interrupt controller with edge inputs, wake-up and one-level shadow context
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.svh"

module vectored_irq_controller #(
  parameter int unsigned EXT_COUNT = 5
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  input  wire logic [EXT_COUNT-1:0] ext_irq_inputs,
  input  wire logic [47:0]        periph_events,
  input  wire logic               instr_cycle_start,
  input  wire logic [3:0]         cpu_priority_level,
  input  wire logic               cpu_low_power,
  input  wire logic               irq_ack,
  input  wire logic               shadow_push,
  input  wire logic               shadow_pop,
  input  wire irq_pkg::context_t  live_context,
  output irq_pkg::context_t       shadow_context,
  output logic                    shadow_restore,
  output irq_pkg::irq_req_t       irq_request,
  output logic                    wake_request,
  output logic                    stack_push,
  output logic      [3:0]         load_priority,
  output logic                    irq_out
);

  if (EXT_COUNT < 1 || EXT_COUNT > 5) begin : g_bad_ext
    $error("EXT_COUNT must lie between 1 and 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  function automatic int unsigned ext_pos(input int unsigned idx);
    case (idx)
      0:       ext_pos = `EXT0_FLAG_BIT;
      1:       ext_pos = `EXT1_FLAG_BIT;
      2:       ext_pos = `EXT2_FLAG_BIT;
      3:       ext_pos = `EXT3_FLAG_BIT;
      default: ext_pos = `EXT4_FLAG_BIT;
    endcase
  endfunction : ext_pos

  function automatic logic [15:0] prio_reset_val(input int unsigned idx);
    case (idx)
      9:       prio_reset_val = `PRIO_RESET_9;
      10:      prio_reset_val = `PRIO_RESET_10;
      default: prio_reset_val = `PRIO_RESET;
    endcase
  endfunction : prio_reset_val

  function automatic logic [15:0] prio_mask(input int unsigned idx);
    case (idx)
      9:       prio_mask = `PRIO_MASK_9;
      10:      prio_mask = `PRIO_MASK_10;
      default: prio_mask = `PRIO_MASK;
    endcase
  endfunction : prio_mask

  function automatic logic [15:0] flag_mask(input int unsigned idx);
    flag_mask = (idx == 2) ? `FLAGS_2_MASK : 16'hFFFF;
  endfunction : flag_mask

  function automatic logic [15:0] prio_ofs(input int unsigned idx);
    case (idx)
      0:       prio_ofs = `OFS_PRIO_0;
      1:       prio_ofs = `OFS_PRIO_1;
      2:       prio_ofs = `OFS_PRIO_2;
      3:       prio_ofs = `OFS_PRIO_3;
      4:       prio_ofs = `OFS_PRIO_4;
      5:       prio_ofs = `OFS_PRIO_5;
      6:       prio_ofs = `OFS_PRIO_6;
      7:       prio_ofs = `OFS_PRIO_7;
      8:       prio_ofs = `OFS_PRIO_8;
      9:       prio_ofs = `OFS_PRIO_9;
      default: prio_ofs = `OFS_PRIO_10;
    endcase
  endfunction : prio_ofs

  function automatic logic [15:0] flag_ofs(input int unsigned idx);
    case (idx)
      0:       flag_ofs = `OFS_FLAGS_0;
      1:       flag_ofs = `OFS_FLAGS_1;
      default: flag_ofs = `OFS_FLAGS_2;
    endcase
  endfunction : flag_ofs

  function automatic logic [15:0] enable_ofs(input int unsigned idx);
    case (idx)
      0:       enable_ofs = `OFS_ENABLES_0;
      1:       enable_ofs = `OFS_ENABLES_1;
      default: enable_ofs = `OFS_ENABLES_2;
    endcase
  endfunction : enable_ofs

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [15:0]                  fault_nesting_control_r;
  logic [15:0]                  edge_and_vector_control_r;
  logic [`FLAG_REG_COUNT-1:0][15:0] request_flags_r;
  logic [`FLAG_REG_COUNT-1:0][15:0] request_enables_r;
  logic [`PRIO_REG_COUNT-1:0][15:0] source_priority_r;
  logic [`EVENT_COUNT-1:0]      event_status_r;
  logic [`EVENT_COUNT-1:0]      event_enable_r;
  logic [EXT_COUNT-1:0]         ext_meta_r;
  logic [EXT_COUNT-1:0]         ext_sync_r;
  logic [EXT_COUNT-1:0]         ext_prev_r;
  logic [47:0]                  event_hold_r;
  logic [2:0]                   ext_fill_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic [`FLAG_REG_COUNT-1:0]   wr_flags;
  logic [`FLAG_REG_COUNT-1:0]   wr_enables;
  logic [`PRIO_REG_COUNT-1:0]   wr_prio;
  logic [`FLAG_REG_COUNT-1:0]   hit_flags;
  logic [`FLAG_REG_COUNT-1:0]   hit_enables;
  logic [`PRIO_REG_COUNT-1:0]   hit_prio;
  logic                         wr_fault_nest;
  logic                         wr_edge_vector;
  logic                         wr_event_enable;
  logic                         wr_event_clear;

  // Strobes qualified by address match
  for (genvar g = 0; g < `FLAG_REG_COUNT; g++) begin : g_flag_dec
    assign hit_flags[g]   = (reg_addr == flag_ofs(g));
    assign hit_enables[g] = (reg_addr == enable_ofs(g));
    assign wr_flags[g]    = reg_wr && hit_flags[g];
    assign wr_enables[g]  = reg_wr && hit_enables[g];
  end

  for (genvar g = 0; g < `PRIO_REG_COUNT; g++) begin : g_prio_dec
    assign hit_prio[g] = (reg_addr == prio_ofs(g));
    assign wr_prio[g]  = reg_wr && hit_prio[g];
  end

  assign wr_fault_nest   = reg_wr && (reg_addr == `OFS_FAULT_NEST);
  assign wr_edge_vector  = reg_wr && (reg_addr == `OFS_EDGE_VECTOR);
  assign wr_event_enable = reg_wr && (reg_addr == `OFS_EVENT_ENABLE);
  assign wr_event_clear  = reg_wr && (reg_addr == `OFS_EVENT_CLEAR);

  ////////////////////////////////////////////////////////////////////////////
  // External edge detection

  logic [EXT_COUNT-1:0] ext_edge;
  logic [47:0]          ext_event_vec;
  logic [47:0]          incoming;

  for (genvar g = 0; g < EXT_COUNT; g++) begin : g_edge
    // No false edge while the pipeline still holds reset values
    assign ext_edge[g] = ext_fill_r[2] && (edge_and_vector_control_r[g]
                         ? (ext_prev_r[g] && !ext_sync_r[g])
                         : (!ext_prev_r[g] && ext_sync_r[g]));
  end

  always_comb begin
    ext_event_vec = 48'h0000_0000_0000;
    for (int i = 0; i < EXT_COUNT; i++) begin
      ext_event_vec[ext_pos(i)] = ext_edge[i];
    end
  end

  assign incoming = periph_events | ext_event_vec;

  // Events land in flags at cycle start
  logic [47:0] flag_set;
  logic [47:0] event_hold_nxt;
  assign flag_set       = instr_cycle_start ? (event_hold_r | incoming) : 48'h0000_0000_0000;
  assign event_hold_nxt = instr_cycle_start ? 48'h0000_0000_0000 : (event_hold_r | incoming);

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  logic [3:0] best_level;
  logic [5:0] best_vector;
  logic       best_hit;

  // Highest enabled level, lowest index on ties
  always_comb begin
    logic [2:0] lvl;
    lvl         = 3'h0;
    best_level  = 4'h0;
    best_vector = 6'h00;
    best_hit    = 1'b0;
    for (int i = 0; i < `SOURCE_COUNT; i++) begin
      // Level zero never beats the start value
      lvl = source_priority_r[i / 4][(i % 4) * 4 +: 3];
      if (request_flags_r[i / 16][i % 16] && request_enables_r[i / 16][i % 16]
          && ({1'b0, lvl} > best_level)) begin
        best_level  = {1'b0, lvl};
        best_vector = 6'(i + `VECTOR_BASE);
        best_hit    = 1'b1;
      end
    end
  end

  logic req_valid_nxt;
  assign req_valid_nxt = best_hit && (best_level > cpu_priority_level);

  irq_pkg::irq_req_t req_nxt;
  assign req_nxt = '{valid:     req_valid_nxt,
                     level:     best_level,
                     vector:    best_vector,
                     alt_table: edge_and_vector_control_r[`ALT_VECTOR_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt line

  logic [`EVENT_COUNT-1:0] event_raise;
  logic [`EVENT_COUNT-1:0] event_status_nxt;
  // Wake on the top bit, external edges below
  assign event_raise = {req_valid_nxt && cpu_low_power,
                        (`EVENT_COUNT-1)'(ext_edge)};
  // A raise wins over a clear in the same cycle
  assign event_status_nxt = (event_status_r & ~(wr_event_clear ? reg_wdata[`EVENT_COUNT-1:0]
                                                                : `EVENT_COUNT'(0)))
                            | event_raise;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [15:0] rd_value;
  always_comb begin
    rd_value = 16'h0000;
    for (int i = 0; i < `FLAG_REG_COUNT; i++) begin
      if (hit_flags[i])   rd_value = request_flags_r[i];
      if (hit_enables[i]) rd_value = request_enables_r[i];
    end
    for (int i = 0; i < `PRIO_REG_COUNT; i++) begin
      if (hit_prio[i]) rd_value = source_priority_r[i];
    end
    case (reg_addr)
      `OFS_FAULT_NEST:    rd_value = fault_nesting_control_r;
      `OFS_EDGE_VECTOR:   rd_value = edge_and_vector_control_r;
      `OFS_ACTIVE_STATUS: rd_value = {4'h0, irq_request.level, 2'b00, irq_request.vector};
      `OFS_EVENT_STATUS:  rd_value = 16'(event_status_r);
      `OFS_EVENT_ENABLE:  rd_value = 16'(event_enable_r);
      // Unmapped and write-only addresses read zero
      default:            ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and data registers

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_nesting_control_r   <= 16'h0000;
      edge_and_vector_control_r <= 16'h0000;
      event_enable_r            <= '0;
      reg_rdata                 <= 16'h0000;
    end else begin
      if (wr_fault_nest)   fault_nesting_control_r   <= reg_wdata & `FAULT_NEST_MASK;
      if (wr_edge_vector)  edge_and_vector_control_r <= reg_wdata & `EDGE_VECTOR_MASK;
      if (wr_event_enable) event_enable_r            <= reg_wdata[`EVENT_COUNT-1:0];
      reg_rdata <= reg_rd ? rd_value : 16'h0000;
    end
  end

  // Flags: hardware set wins over a software write
  for (genvar g = 0; g < `FLAG_REG_COUNT; g++) begin : g_flag_regs
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        request_flags_r[g]   <= 16'h0000;
        request_enables_r[g] <= 16'h0000;
      end else begin
        request_flags_r[g] <= ((wr_flags[g] ? reg_wdata : request_flags_r[g])
                               | flag_set[g*16 +: 16]) & flag_mask(g);
        if (wr_enables[g]) request_enables_r[g] <= reg_wdata & flag_mask(g);
      end
    end
  end

  for (genvar g = 0; g < `PRIO_REG_COUNT; g++) begin : g_prio_regs
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        source_priority_r[g] <= prio_reset_val(g);
      end else if (wr_prio[g]) begin
        source_priority_r[g] <= reg_wdata & prio_mask(g);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and event capture

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_meta_r   <= '0;
      ext_sync_r   <= '0;
      ext_prev_r   <= '0;
      event_hold_r <= 48'h0000_0000_0000;
      ext_fill_r   <= 3'h0;
    end else begin
      ext_meta_r   <= ext_irq_inputs;
      ext_sync_r   <= ext_meta_r;
      ext_prev_r   <= ext_sync_r;
      event_hold_r <= event_hold_nxt;
      // Marks the stages that hold real pin samples
      ext_fill_r   <= {ext_fill_r[1:0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing request, wake and take sequence

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_request    <= '0;
      wake_request   <= 1'b0;
      stack_push     <= 1'b0;
      load_priority  <= 4'h0;
      event_status_r <= '0;
      irq_out        <= 1'b0;
    end else begin
      irq_request    <= req_nxt;
      wake_request   <= req_valid_nxt && cpu_low_power;
      stack_push     <= irq_ack && irq_request.valid;
      if (irq_ack && irq_request.valid) load_priority <= irq_request.level;
      // Sticky event bits and their level line
      event_status_r <= event_status_nxt;
      irq_out        <= |(event_status_nxt & event_enable_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow context
  // No register address reaches the shadow

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shadow_context <= '0;
      shadow_restore <= 1'b0;
    end else begin
      if (shadow_push) shadow_context <= live_context;
      shadow_restore <= shadow_pop;
    end
  end

endmodule : vectored_irq_controller

`default_nettype wire

// ===== verification/irq_core_model.sv
// Behavioural processor core facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire irq_pkg::irq_req_t irq_request,
  input  wire logic              wake_request,
  input  wire logic              stack_push,
  input  wire logic [3:0]        load_priority,
  input  wire logic [3:0]        base_level,
  input  wire logic              slow,
  input  wire logic              go_sleep,
  input  wire logic              isr_exit,
  input  wire logic              keep,
  output logic                   irq_ack,
  output logic [3:0]             cpu_priority_level,
  output logic                   cpu_low_power,
  output logic                   shadow_push,
  output logic                   shadow_pop,
  output irq_pkg::context_t      live_context,
  output irq_pkg::context_t      saved_ctx,
  output logic                   in_isr
);
  logic [3:0]  isr_lvl_r;
  logic [1:0]  wait_r;
  logic        pend_r;
  logic [95:0] rnd;

  assign cpu_priority_level = in_isr ? isr_lvl_r : base_level;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {irq_ack, cpu_low_power, shadow_push, shadow_pop, in_isr, pend_r} <= '0;
      {isr_lvl_r, wait_r} <= '0;
      live_context <= '0;
      saved_ctx <= '0;
    end else begin
      rnd = {$urandom(), $urandom(), $urandom()};
      irq_ack <= 1'b0;
      shadow_push <= 1'b0;
      shadow_pop <= 1'b0;
      live_context <= rnd[68:0];
      // Slow mode holds off the acknowledge
      if (irq_request.valid && !in_isr && !pend_r) begin
        if (!slow || wait_r == 2'd3) begin
          irq_ack <= 1'b1;
          pend_r <= 1'b1;
          wait_r <= 2'd0;
        end else begin
          wait_r <= wait_r + 2'd1;
        end
      end
      if (stack_push) begin
        in_isr <= 1'b1;
        pend_r <= 1'b0;
        isr_lvl_r <= load_priority;
        shadow_push <= 1'b1;
        saved_ctx <= rnd[68:0];
      end
      if (isr_exit && in_isr) begin
        in_isr <= 1'b0;
        shadow_pop <= !keep;
      end
      if (go_sleep) cpu_low_power <= 1'b1;
      else if (wake_request) cpu_low_power <= 1'b0;
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ===== verification/vectored_irq_controller_sva.sv
// Port-level checks for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_controller_sva (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic [3:0]        cpu_priority_level,
  input wire logic              cpu_low_power,
  input wire logic              irq_ack,
  input wire logic              shadow_push,
  input wire logic              shadow_pop,
  input wire irq_pkg::context_t live_context,
  input wire irq_pkg::context_t shadow_context,
  input wire logic              shadow_restore,
  input wire irq_pkg::irq_req_t irq_request,
  input wire logic              wake_request,
  input wire logic              stack_push,
  input wire logic [3:0]        load_priority
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_take; irq_ack && irq_request.valid; endsequence
  sequence s_stack; stack_push && load_priority == $past(irq_request.level); endsequence

  property p_take; s_take |=> s_stack; endproperty
  a_take: assert property (p_take) else $error("take without stack push");
  property p_stack; stack_push |-> $past(irq_ack && irq_request.valid); endproperty
  a_stack: assert property (p_stack) else $error("stray stack push");
  property p_level; irq_request.valid |-> irq_request.level > $past(cpu_priority_level)
    && irq_request.level <= 4'd7; endproperty
  a_level: assert property (p_level) else $error("request not above level");
  property p_vec; irq_request.valid |-> irq_request.vector inside {[8:51]}; endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_wake; irq_request.valid && cpu_low_power |-> ##[0:1] wake_request; endproperty
  a_wake: assert property (p_wake) else $error("no wake in low power");
  property p_wake_src; wake_request |-> $past(cpu_low_power); endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake while awake");
  property p_push; shadow_push |=> shadow_context == $past(live_context); endproperty
  a_push: assert property (p_push) else $error("shadow not saved");
  property p_hold; !shadow_push |=> $stable(shadow_context); endproperty
  a_hold: assert property (p_hold) else $error("shadow changed");
  property p_pop; shadow_pop |=> shadow_restore; endproperty
  a_pop: assert property (p_pop) else $error("no restore after pop");
  property p_restore; shadow_restore |-> $past(shadow_pop); endproperty
  a_restore: assert property (p_restore) else $error("stray restore");
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule : vectored_irq_controller_sva
`default_nettype wire

// ===== verification/vectored_irq_controller_test.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_consts.svh"
module vectored_irq_controller_test;
  logic              clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, instr_cycle_start = 0;
  logic [15:0]       reg_addr = '0, reg_wdata = '0, reg_rdata, fo;
  logic [4:0]        ext_irq_inputs = '0;
  logic [47:0]       periph_events = '0;
  logic [3:0]        cpu_priority_level, load_priority, lvl, base_level = '0;
  logic              cpu_low_power, irq_ack, shadow_push, shadow_pop, shadow_restore;
  logic              wake_request, stack_push, irq_out, in_isr, pol, alt, rd_d = 0;
  logic              slow = 0, go_sleep = 0, isr_exit = 0, keep = 0;
  irq_pkg::context_t live_context, shadow_context, saved_ctx;
  irq_pkg::irq_req_t irq_request;
  logic [15:0]       r_q[$];
  logic [11:0]       t_q[$];
  int                error_cnt = 0, cmp_count = 0, cyc = 0, b, s;
  localparam logic [31:0] RST [11] = '{{`OFS_PRIO_0, `PRIO_RESET}, {`OFS_PRIO_1, `PRIO_RESET},
    {`OFS_PRIO_5, `PRIO_RESET}, {`OFS_PRIO_9, `PRIO_RESET_9}, {`OFS_PRIO_10, `PRIO_RESET_10},
    {`OFS_EDGE_VECTOR, 16'h0000}, {`OFS_FAULT_NEST, 16'h0000}, {`OFS_ACTIVE_STATUS, 16'h0000},
    {`OFS_ENABLES_2, 16'h0000}, {`OFS_EVENT_CLEAR, 16'h0000}, {16'h00AA, 16'h0000}};
  localparam int          EXT_BIT [5] = '{0, 16, 23, 36, 37};
  localparam int          SRC [4] = '{0, 5, 23, 37};
  localparam int          SH [4] = '{0, 4, 12, 4};
  localparam logic [15:0] PO [4] = '{`OFS_PRIO_0, `OFS_PRIO_1, `OFS_PRIO_5, `OFS_PRIO_9};
  localparam logic [15:0] EO [4] = '{`OFS_ENABLES_0, `OFS_ENABLES_0, `OFS_ENABLES_1,
    `OFS_ENABLES_2};

  vectored_irq_controller i_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq_inputs, .periph_events, .instr_cycle_start, .cpu_priority_level,
    .cpu_low_power, .irq_ack, .shadow_push, .shadow_pop, .live_context, .shadow_context,
    .shadow_restore, .irq_request, .wake_request, .stack_push, .load_priority, .irq_out);
  irq_core_model i_core (.clk, .reset, .irq_request, .wake_request, .stack_push,
    .load_priority, .base_level, .slow, .go_sleep, .isr_exit, .keep, .irq_ack,
    .cpu_priority_level, .cpu_low_power, .shadow_push, .shadow_pop, .live_context,
    .saved_ctx, .in_isr);

  always #10 clk = !clk;
  always @(posedge clk) instr_cycle_start <= !instr_cycle_start;

  task automatic fail(input string m);
    error_cnt++;
    $display("Error at %0t: %s", $time, m);
  endtask : fail

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // One register cycle; a read notes its expected data
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) r_q.push_back(d);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : acc

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) fail(m);
  endtask : chk

  // Watcher: pairs each read and taken request with the oldest note
  always @(posedge clk) begin
    if (rd_d) begin
      cmp_count++;
      if (reg_rdata !== r_q.pop_front()) fail("read data");
    end
    rd_d = reg_rd;
    if (irq_ack && irq_request.valid) begin
      cmp_count++;
      if (irq_request !== t_q.pop_front()) fail("taken request");
    end
    if (shadow_restore) begin
      cmp_count++;
      if (shadow_context !== saved_ctx) fail("restored context");
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail("timeout");
      close_out();
    end
  end

  initial begin
    void'($urandom(96));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (RST[i]) acc(1'b0, RST[i][31:16], RST[i][15:0]);
    acc(1'b1, `OFS_ACTIVE_STATUS, 16'hFFFF);
    acc(1'b0, `OFS_ACTIVE_STATUS, 16'h0000);
    acc(1'b1, `OFS_PRIO_9, 16'hFFFF);
    acc(1'b0, `OFS_PRIO_9, 16'h0777);
    acc(1'b1, `OFS_FAULT_NEST, 16'hFFFF);
    acc(1'b0, `OFS_FAULT_NEST, `FAULT_NEST_MASK);
    acc(1'b1, `OFS_EDGE_VECTOR, 16'hFFFF);
    acc(1'b0, `OFS_EDGE_VECTOR, `EDGE_VECTOR_MASK);
    $display("Test registers done");
    for (int e = 0; e < 5; e++) begin
      pol = 1'($urandom());
      b = EXT_BIT[e];
      fo = 16'h0084 + 16'(2 * (b / 16));
      acc(1'b1, `OFS_EDGE_VECTOR, 16'(pol) << e);
      ext_irq_inputs[e] <= pol;
      repeat (8) @(posedge clk);
      acc(1'b1, fo, 16'h0000);
      acc(1'b1, `OFS_EVENT_CLEAR, 16'h003F);
      ext_irq_inputs[e] <= !pol;
      repeat (8) @(posedge clk);
      acc(1'b0, fo, 16'(1) << (b % 16));
      acc(1'b0, `OFS_EVENT_STATUS, 16'(1) << e);
      chk(!irq_out, "masked event raised line");
      acc(1'b1, `OFS_EVENT_ENABLE, 16'(1) << e);
      repeat (2) @(posedge clk);
      chk(irq_out, "enabled event kept line low");
      acc(1'b1, `OFS_EVENT_CLEAR, 16'(1) << e);
      repeat (2) @(posedge clk);
      chk(!irq_out, "cleared event kept line high");
      acc(1'b1, fo, 16'h0000);
      ext_irq_inputs[e] <= pol;
      repeat (8) @(posedge clk);
      acc(1'b0, fo, 16'h0000);
    end
    acc(1'b1, `OFS_EVENT_ENABLE, 16'h0000);
    $display("Test external edges done");
    for (int n = 0; n < 12; n++) begin
      s = SRC[n % 4];
      lvl = 4'($urandom_range(1, 7));
      alt = 1'($urandom());
      base_level <= 4'($urandom_range(0, 4));
      slow <= 1'($urandom());
      keep <= 1'($urandom());
      go_sleep <= 1'($urandom());
      acc(1'b1, `OFS_EDGE_VECTOR, {alt, 15'h0000});
      go_sleep <= 1'b0;
      acc(1'b1, PO[n % 4], 16'(lvl) << SH[n % 4]);
      acc(1'b1, EO[n % 4], 16'(1) << (s % 16));
      if (lvl > base_level) t_q.push_back({1'b1, lvl, 6'(s + 8), alt});
      periph_events[s] <= 1'b1;
      @(posedge clk);
      periph_events[s] <= 1'b0;
      for (int k = 0; k < 40 && !in_isr; k++) @(posedge clk);
      acc(1'b1, 16'h0084 + 16'(2 * (s / 16)), 16'h0000);
      acc(1'b1, EO[n % 4], 16'h0000);
      isr_exit <= 1'b1;
      @(posedge clk);
      isr_exit <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chk(t_q.size() == 0, "expected request never taken");
    $display("Test requests done");
    close_out();
  end
endmodule : vectored_irq_controller_test

bind vectored_irq_controller vectored_irq_controller_sva i_sva (.clk, .reset, .reg_rd,
  .reg_rdata, .cpu_priority_level, .cpu_low_power, .irq_ack, .shadow_push, .shadow_pop,
  .live_context, .shadow_context, .shadow_restore, .irq_request, .wake_request,
  .stack_push, .load_priority);
`default_nettype wire
